//--- rtl/upm_io_map.sv
// user program io map: uptime object, three selection tables, copy sequencer
`timescale 1ns/1ps
module upm_io_map
  import upm_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = UPM_TICKS_PER_SEC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // fieldbus dictionary access
  input wire logic odReq,
  input wire logic odWrite,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSub,
  output logic odAck,
  output logic [31:0] odRdata,
  output logic [15:0] odAbort,
  // program loader fills the tables
  input wire logic ldValid,
  input wire logic [1:0] ldTable,
  input wire logic [3:0] ldSlot,
  input wire logic [31:0] ldEntry,
  // run cycle of the user program
  input wire logic preReq,
  input wire logic postReq,
  output logic phaseDone,
  output logic busy,
  // object copy port
  output logic objValid,
  output logic objWrite,
  output logic [15:0] objIndex,
  output logic [7:0] objSub,
  output logic [7:0] objBits,
  output logic [1:0] objTable,
  output logic [3:0] objSlot,
  input wire logic objReady,
  input wire logic objOk,
  // mapping error
  output logic mapErr,
  output logic [31:0] mapErrCode
);

  // refuse a prescaler that cannot count
  if (TICKS_PER_SEC < 1) begin : g_chk
    $error("upm_io_map: TICKS_PER_SEC must be at least one");
  end

  typedef struct packed {
    logic [2:0][UPM_ENTRIES-1:0][31:0] tab; // in, out, inout selection tables
    logic ack;              // dictionary answer strobe
    logic [31:0] rdata;     // dictionary read value
    logic [15:0] abort;     // dictionary abort code
    upm_state_e st;         // copy sequencer state
    logic post;             // walking the after-run direction
    logic pass;             // 0 first table, 1 inout table
    logic [3:0] slot;       // entry under work
    logic err;              // a mapping error was seen this cycle of runs
    logic [31:0] errCode;   // code of the first failing entry
  } upm_io_s;

  upm_io_s state_r;
  upm_io_s state_nxt;
  logic [31:0] seconds; // uptime from the prescaled counter
  logic [1:0] curTbl;   // table walked right now
  logic [31:0] curEntry;
  logic isTbl;          // dictionary index hits a table
  logic [1:0] odTbl;

  ////////////////////////////////////////////////////////////////////////////
  // uptime counter
  upm_uptime #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_uptime (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .seconds(seconds)
  );

  ////////////////////////////////////////////////////////////////////////////
  // current table and entry of the walk
  always_comb begin
    if (state_r.pass) begin
      curTbl = UPM_TBL_INOUT;
    end else if (state_r.post) begin
      curTbl = UPM_TBL_OUT;
    end else begin
      curTbl = UPM_TBL_IN;
    end
    curEntry = state_r.tab[curTbl][state_r.slot];
  end

  // dictionary index decode
  always_comb begin
    isTbl = 1'b1;
    odTbl = UPM_TBL_IN;
    case (odIndex)
      UPM_IDX_IN_SEL: odTbl = UPM_TBL_IN;
      UPM_IDX_OUT_SEL: odTbl = UPM_TBL_OUT;
      UPM_IDX_INOUT_SEL: odTbl = UPM_TBL_INOUT;
      default: isTbl = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.ack = 1'b0;

    // loader writes an entry; the fieldbus never can
    if (ldValid && ldTable != 2'h3) begin
      state_nxt.tab[ldTable][ldSlot] = ldEntry;
    end

    // dictionary answer one cycle after the request
    if (odReq) begin
      state_nxt.ack = 1'b1;
      state_nxt.rdata = 32'h0000_0000;
      state_nxt.abort = UPM_AB_NONE;
      if (odIndex == UPM_IDX_UPTIME && odSub == UPM_SUB_COUNT) begin
        if (odWrite) begin
          state_nxt.abort = UPM_AB_WRITE_PROT;
        end else begin
          state_nxt.rdata = seconds;
        end
      end else if (isTbl && odSub <= 8'(UPM_ENTRIES)) begin
        if (odWrite) begin
          state_nxt.abort = UPM_AB_WRITE_PROT;
        end else if (odSub == UPM_SUB_COUNT) begin
          state_nxt.rdata = UPM_COUNT_VALUE;
        end else begin
          state_nxt.rdata = state_r.tab[odTbl][4'(odSub - UPM_SUB_FIRST)];
        end
      end else begin
        state_nxt.abort = UPM_AB_NO_OBJECT;
      end
    end

    // copy sequencer
    case (state_r.st)
      UPM_IDLE: begin
        if (preReq || postReq) begin
          state_nxt.st = UPM_WALK;
          state_nxt.post = postReq && !preReq;
          state_nxt.pass = 1'b0;
          state_nxt.slot = 4'h0;
          if (preReq) begin
            state_nxt.err = 1'b0;
            state_nxt.errCode = 32'h0000_0000;
          end
        end
      end
      UPM_WALK: begin
        // empty entries are skipped, others wait for the object port
        if (curEntry == UPM_ENTRY_RESET || objReady) begin
          if (curEntry != UPM_ENTRY_RESET && !objOk && !state_r.err) begin
            state_nxt.err = 1'b1;
            state_nxt.errCode = {UPM_ERR_MAP_TAG, curEntry[31:8]};
          end
          if (state_r.slot == 4'(UPM_ENTRIES - 1)) begin
            state_nxt.slot = 4'h0;
            if (state_r.pass) begin
              state_nxt.st = UPM_DONE;
            end else begin
              state_nxt.pass = 1'b1;
            end
          end else begin
            state_nxt.slot = state_r.slot + 4'h1;
          end
        end
      end
      UPM_DONE: begin
        state_nxt.st = UPM_IDLE;
      end
      default: begin
        state_nxt.st = UPM_IDLE;
      end
    endcase
  end

  // state register; tables start empty
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r.tab <= '0;
      state_r.ack <= 1'b0;
      state_r.rdata <= 32'h0000_0000;
      state_r.abort <= UPM_AB_NONE;
      state_r.st <= UPM_IDLE;
      state_r.post <= 1'b0;
      state_r.pass <= 1'b0;
      state_r.slot <= 4'h0;
      state_r.err <= 1'b0;
      state_r.errCode <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign odAck = state_r.ack;
  assign odRdata = state_r.rdata;
  assign odAbort = state_r.abort;
  assign busy = state_r.st != UPM_IDLE;
  assign phaseDone = state_r.st == UPM_DONE;
  // in before the run, out after it
  assign objValid = state_r.st == UPM_WALK && curEntry != UPM_ENTRY_RESET;
  assign objWrite = state_r.post;
  assign objIndex = curEntry[31:UPM_F_INDEX_LSB];
  assign objSub = curEntry[UPM_F_INDEX_LSB-1:UPM_F_SUB_LSB];
  assign objBits = curEntry[UPM_F_SUB_LSB-1:UPM_F_BITS_LSB];
  assign objTable = curTbl;
  assign objSlot = state_r.slot;
  assign mapErr = state_r.err;
  assign mapErrCode = state_r.errCode;
endmodule : upm_io_map

//--- pkg/upm_pkg.sv
// constants, types and layout of the user program io map object bank
package upm_pkg;
  // dictionary indices of the objects in this bank
  localparam logic [15:0] UPM_IDX_UPTIME = 16'h230F;
  localparam logic [15:0] UPM_IDX_IN_SEL = 16'h2310;
  localparam logic [15:0] UPM_IDX_OUT_SEL = 16'h2320;
  localparam logic [15:0] UPM_IDX_INOUT_SEL = 16'h2330;
  // subindex layout of a selection table
  localparam logic [7:0] UPM_SUB_COUNT = 8'h00;
  localparam logic [7:0] UPM_SUB_FIRST = 8'h01;
  localparam int UPM_ENTRIES = 16;
  localparam logic [31:0] UPM_COUNT_VALUE = 32'h0000_0010;
  // mapping entry field positions
  localparam int UPM_F_INDEX_LSB = 16;
  localparam int UPM_F_SUB_LSB = 8;
  localparam int UPM_F_BITS_LSB = 0;
  // reset values
  localparam logic [31:0] UPM_UPTIME_RESET = 32'h0000_0000;
  localparam logic [31:0] UPM_ENTRY_RESET = 32'h0000_0000;
  // dictionary abort codes
  localparam logic [15:0] UPM_AB_NONE = 16'h0000;
  localparam logic [15:0] UPM_AB_NO_OBJECT = 16'h1000;
  localparam logic [15:0] UPM_AB_WRITE_PROT = 16'h1001;
  // error code for an entry that cannot be mapped: 1 xxxx yy
  localparam logic [7:0] UPM_ERR_MAP_TAG = 8'h01;
  // timing: one second at the reference clock
  localparam int UPM_SECOND_NS = 1_000_000_000;
  localparam int UPM_CLK_NS = 40;
  localparam int UPM_TICKS_PER_SEC = UPM_SECOND_NS / UPM_CLK_NS;
  // table selectors
  localparam logic [1:0] UPM_TBL_IN = 2'h0;
  localparam logic [1:0] UPM_TBL_OUT = 2'h1;
  localparam logic [1:0] UPM_TBL_INOUT = 2'h2;
  // copy sequencer states
  typedef enum logic [1:0] {UPM_IDLE, UPM_WALK, UPM_DONE} upm_state_e;
endpackage : upm_pkg

//--- rtl/upm_uptime.sv
// free-running seconds counter with a one second prescaler
`timescale 1ns/1ps
module upm_uptime
  import upm_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = UPM_TICKS_PER_SEC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // seconds value
  output logic [31:0] seconds
);
  localparam int PW = (TICKS_PER_SEC > 1) ? $clog2(TICKS_PER_SEC) : 1;
  localparam logic [PW-1:0] LAST = PW'(TICKS_PER_SEC - 1);

  // refuse a prescaler that cannot count
  if (TICKS_PER_SEC < 1) begin : g_chk
    $error("upm_uptime: TICKS_PER_SEC must be at least one");
  end

  typedef struct packed {
    logic [PW-1:0] pre; // clock cycles within the current second
    logic [31:0] sec;   // whole seconds since reset
  } upm_up_s;

  upm_up_s state_r;
  upm_up_s state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next state: roll the prescaler, bump seconds once per roll
  always_comb begin
    state_nxt = state_r;
    if (state_r.pre == LAST) begin
      state_nxt.pre = '0;
      state_nxt.sec = state_r.sec + 32'h0000_0001;
    end else begin
      state_nxt.pre = state_r.pre + PW'(1);
    end
  end

  // power-up clears the count, nothing is kept
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r.pre <= '0;
      state_r.sec <= UPM_UPTIME_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign seconds = state_r.sec;
endmodule : upm_uptime

//--- tb/upm_obj_partner.sv
// far-side object store model for the copy port
`timescale 1ns/1ps
module upm_obj_partner
  import upm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // copy port
  input wire logic objValid,
  input wire logic [15:0] objIndex,
  output logic objReady,
  output logic objOk,
  // knobs and count
  input wire logic [1:0] lat,
  input wire logic [15:0] badIdx,
  output int nXfer
);
  logic [1:0] waitCnt_r; // idle cycles spent on the current entry
  // accept after lat cycles, refuse only the named object
  assign objReady = objValid && waitCnt_r == lat;
  assign objOk = objIndex != badIdx;
  // count wait cycles and accepted transfers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r <= 2'h0;
      nXfer <= 0;
    end else if (objReady) begin
      waitCnt_r <= 2'h0;
      nXfer <= nXfer + 1;
    end else if (objValid) begin
      waitCnt_r <= waitCnt_r + 2'h1;
    end
  end
endmodule : upm_obj_partner

//--- tb/upm_io_map_chk.sv
// port assertions for the io map object bank
`timescale 1ns/1ps
module upm_io_map_chk
  import upm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // dictionary
  input wire logic odReq,
  input wire logic odWrite,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSub,
  input wire logic odAck,
  input wire logic [31:0] odRdata,
  input wire logic [15:0] odAbort,
  // copy walk
  input wire logic busy,
  input wire logic phaseDone,
  input wire logic objValid,
  input wire logic objWrite,
  input wire logic [1:0] objTable,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSub,
  input wire logic objReady,
  input wire logic objOk,
  input wire logic mapErr,
  input wire logic [31:0] mapErrCode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // first refused entry since the last before-run walk began
  sequence s_fail; objValid && objReady && !objOk && !mapErr; endsequence
  property p_ack; odReq |=> odAck; endproperty
  // any write to a table subindex 0..16 is refused, whichever table it names
  property p_ro; odReq && odWrite && (odIndex == UPM_IDX_IN_SEL ||
    odIndex == UPM_IDX_OUT_SEL || odIndex == UPM_IDX_INOUT_SEL) && odSub <= 8'h10 |=>
    odAbort == UPM_AB_WRITE_PROT; endproperty
  property p_cnt; odReq && !odWrite && odIndex == UPM_IDX_OUT_SEL && odSub == 8'h00 |=>
    odRdata == UPM_COUNT_VALUE && odAbort == UPM_AB_NONE; endproperty
  property p_hold; objValid && !objReady |=> objValid && $stable(objIndex); endproperty
  property p_err; s_fail |=>
    mapErr && mapErrCode == {UPM_ERR_MAP_TAG, $past(objIndex), $past(objSub)}; endproperty
  property p_dirIn; objValid && objTable == UPM_TBL_IN |-> !objWrite; endproperty
  property p_dirOut; objValid && objTable == UPM_TBL_OUT |-> objWrite; endproperty
  property p_done; phaseDone |-> busy ##1 !busy; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  a_ro: assert property (p_ro) else $error("write taken");
  a_cnt: assert property (p_cnt) else $error("bad count");
  a_hold: assert property (p_hold) else $error("entry dropped");
  a_err: assert property (p_err) else $error("bad map code");
  a_dirIn: assert property (p_dirIn) else $error("input copied out");
  a_dirOut: assert property (p_dirOut) else $error("output copied in");
  a_done: assert property (p_done) else $error("busy after done");
endmodule : upm_io_map_chk
bind upm_io_map upm_io_map_chk i_chk (.ref_clk, .rst_b, .odReq, .odWrite, .odIndex,
  .odSub, .odAck, .odRdata, .odAbort, .busy, .phaseDone, .objValid, .objWrite, .objTable,
  .objIndex, .objSub, .objReady, .objOk, .mapErr, .mapErrCode);

//--- tb/upm_io_map_tb.sv
// self-checking bench for the io map object bank
`timescale 1ns/1ps
module upm_io_map_tb
  import upm_pkg::*;
;
  logic ref_clk = '0, rst_b = '0, odReq = '0, odWrite = '0, ldValid = '0;
  logic preReq = '0, postReq = '0, odAck, phaseDone, busy, objValid, objWrite;
  logic objReady, objOk, mapErr;
  logic [1:0] ldTable = '0, lat = '0, objTable;
  logic [3:0] ldSlot = '0, objSlot;
  logic [7:0] odSub = '0, objSub, objBits;
  logic [15:0] odIndex = '0, badIdx = '0, odAbort, objIndex;
  logic [31:0] ldEntry = '0, odRdata, mapErrCode;
  logic [15:0] tix [3] = '{UPM_IDX_IN_SEL, UPM_IDX_OUT_SEL, UPM_IDX_INOUT_SEL};
  int num_errors = 0, n_compared = 0, nXfer, n0;
  logic [31:0] lastXfer = '0; // index, subindex and size of the last accepted copy
  logic [5:0] lastPos = '0;   // table and slot of the last accepted copy
  // note every copy that the far side accepts, as it sees it at the edge
  always @(posedge ref_clk) begin
    if (objValid === 1'b1 && objReady === 1'b1) begin
      lastXfer <= {objIndex, objSub, objBits};
      lastPos <= {objTable, objSlot};
    end
  end
  // 25 MHz reference clock
  always #20 ref_clk = ~ref_clk;
  // device with a four-tick second
  upm_io_map #(.TICKS_PER_SEC(4)) i_dut (.ref_clk, .rst_b, .odReq, .odWrite, .odIndex,
    .odSub, .odAck, .odRdata, .odAbort, .ldValid, .ldTable, .ldSlot, .ldEntry, .preReq,
    .postReq, .phaseDone, .busy, .objValid, .objWrite, .objIndex, .objSub, .objBits,
    .objTable, .objSlot, .objReady, .objOk, .mapErr, .mapErrCode);
  // object store on the far side
  upm_obj_partner i_obj (.ref_clk, .rst_b, .objValid, .objIndex, .objReady, .objOk,
    .lat, .badIdx, .nXfer);
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one dictionary access, answer seen one cycle later
  task automatic od(input logic [15:0] i, input logic [7:0] s, input logic w,
    input logic [31:0] d, input logic [15:0] ab);
    @(posedge ref_clk);
    odReq <= 1'h1;
    odWrite <= w;
    odIndex <= i;
    odSub <= s;
    @(posedge ref_clk);
    odReq <= 1'h0;
    #1;
    chk("odAck", 32'h1, {31'h0, odAck});
    chk("odAbort", {16'h0, ab}, {16'h0, odAbort});
    if (ab == 16'h0) chk("odRdata", d, odRdata);
  endtask : od
  task automatic ld(input logic [1:0] t, input logic [3:0] s, input logic [31:0] e);
    @(posedge ref_clk);
    ldValid <= 1'h1;
    ldTable <= t;
    ldSlot <= s;
    ldEntry <= e;
    @(posedge ref_clk);
    ldValid <= 1'h0;
  endtask : ld
  // one copy walk, n transfers expected
  task automatic run(input logic pre, input int n);
    n0 = nXfer;
    @(posedge ref_clk);
    preReq <= pre;
    postReq <= !pre;
    @(posedge ref_clk);
    preReq <= 1'h0;
    postReq <= 1'h0;
    repeat (200) begin
      @(posedge ref_clk);
      #1;
      if (phaseDone === 1'h1) break;
    end
    chk("phaseDone", 32'h1, {31'h0, phaseDone});
    chk("copies", 32'(n), 32'(nXfer - n0));
  endtask : run
  task automatic results();
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'h1;
    od(UPM_IDX_UPTIME, 8'h00, 1'h0, 32'h0, 16'h0);
    repeat (38) @(posedge ref_clk);
    od(UPM_IDX_UPTIME, 8'h00, 1'h0, 32'h0000_000A, 16'h0);
    od(UPM_IDX_UPTIME, 8'h00, 1'h1, 32'h0, UPM_AB_WRITE_PROT);
    @(posedge ref_clk);
    rst_b <= 1'h0;
    @(posedge ref_clk);
    rst_b <= 1'h1;
    od(UPM_IDX_UPTIME, 8'h00, 1'h0, 32'h0, 16'h0);
    for (int t = 0; t < 3; t++) begin
      od(tix[t], 8'h00, 1'h0, UPM_COUNT_VALUE, 16'h0);
      od(tix[t], 8'h10, 1'h0, UPM_ENTRY_RESET, 16'h0);
      od(tix[t], 8'h01, 1'h1, 32'h0, UPM_AB_WRITE_PROT);
      od(tix[t], 8'h11, 1'h0, 32'h0, UPM_AB_NO_OBJECT);
    end
    ld(UPM_TBL_IN, 4'h0, 32'h6040_0010);
    ld(UPM_TBL_IN, 4'hF, 32'h60FF_0220);
    ld(UPM_TBL_OUT, 4'h3, 32'h2500_0520);
    ld(UPM_TBL_INOUT, 4'h2, 32'h2400_0120);
    od(UPM_IDX_IN_SEL, 8'h10, 1'h0, 32'h60FF_0220, 16'h0);
    od(UPM_IDX_OUT_SEL, 8'h04, 1'h0, 32'h2500_0520, 16'h0);
    lat <= 2'h2;
    run(1'h1, 3);
    chk("lastXfer", 32'h2400_0120, lastXfer);
    chk("lastPos", 32'h0000_0022, {26'h0, lastPos});
    lat <= 2'h0;
    run(1'h0, 2);
    chk("lastPos", 32'h0000_0022, {26'h0, lastPos});
    badIdx <= 16'h60FF;
    run(1'h1, 3);
    chk("mapErr", 32'h1, {31'h0, mapErr});
    chk("mapErrCode", 32'h0160_FF02, mapErrCode);
    badIdx <= 16'h0;
    run(1'h1, 3);
    chk("mapErr", 32'h0, {31'h0, mapErr});
    results();
  end
  // watchdog against a hung walk
  initial begin
    repeat (2000) @(posedge ref_clk);
    num_errors++;
    results();
  end
endmodule : upm_io_map_tb
